// >>> hw/dec_pkg.sv
// Operation
// - Only distances inside near/far window count.
// - Entered limits rounded to representable step.
// - Limits default physical; linear 200-1000 mm.
// - Edge mode asserts output on qualifying change.
// - Difference must lie between min and max.
// - Hysteresis separates switch-on and switch-off.
// - Direction filter: both, positive or negative.
// - Compare with value N cycles earlier.
// - One measurement per cycle time.
// - Auto mode picks fastest stable cycle.
// - Fixed mode uses selected time as maximum.
// - Measuring starts from reset without action.
// - Relative value includes offset, absolute excludes.
// - Analog value shown only when enabled.
// - Low signal level gives no valid distance.
// - Window and edge settings need advanced level; the edge mode bit in CTRL is written at any level.
package dec_pkg;
   // ======================================================================
   // Register offsets (byte addresses).
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_NEAR   = 8'h04;
   localparam logic [7:0] A_FAR    = 8'h08;
   localparam logic [7:0] A_HMIN   = 8'h0C;
   localparam logic [7:0] A_HMAX   = 8'h10;
   localparam logic [7:0] A_HYST   = 8'h14;
   localparam logic [7:0] A_COFS   = 8'h18;
   localparam logic [7:0] A_OFFS   = 8'h1C;
   localparam logic [7:0] A_STAT   = 8'h20;
   localparam logic [7:0] A_MASK   = 8'h24;
   localparam logic [7:0] A_DIST   = 8'h28;
   localparam logic [7:0] A_REL    = 8'h2C;
   localparam logic [7:0] A_ANA    = 8'h30;
   localparam logic [7:0] A_INFO   = 8'h34;
   // ======================================================================
   // Control field positions.
   localparam int C_RUN  = 0;
   localparam int C_AUTO = 1;
   localparam int C_SEL  = 2;
   localparam int C_ADV  = 5;
   localparam int C_ANA  = 6;
   localparam int C_DIR  = 7;
   localparam int C_EDGE = 9;
   // Status bit positions.
   localparam int S_MEAS = 0;
   localparam int S_RISE = 1;
   localparam int S_FALL = 2;
   localparam int S_INV  = 3;
   // Info field positions.
   localparam int I_Q    = 16;
   localparam int I_LIN  = 17;
   localparam int I_SEL  = 18;
   // ======================================================================
   // Distances are in units of 0.1 mm.
   localparam logic [15:0] PHYS_NEAR = 16'h07D0;
   localparam logic [15:0] PHYS_FAR  = 16'h2710;
   localparam logic [15:0] LIN_MIN   = 16'h07D0;
   localparam logic [15:0] LIN_MAX   = 16'h2710;
   localparam logic [15:0] DISC_MASK = 16'h0003;
   localparam logic [17:0] RST_HMIN  = 18'h0_0064;
   localparam logic [17:0] RST_HMAX  = 18'h0_03E8;
   localparam logic [17:0] HMAG_MAX  = 18'h1_869F;
   localparam logic [10:0] RST_HYST  = 11'h005;
   localparam logic [10:0] HYST_MAX  = 11'h3E8;
   localparam logic [8:0]  RST_COFS  = 9'h008;
   localparam logic [8:0]  COFS_MAX  = 9'h100;
   localparam logic [17:0] RST_OFFS  = 18'h3_E890;
   localparam logic [11:0] LEVEL_MIN = 12'h040;
   localparam logic [9:0]  RST_CTRL  = 10'h003;
   // ======================================================================
   // Direction filter codes.
   typedef enum logic [1:0] {DIR_BOTH, DIR_POS, DIR_NEG, DIR_RSV} dec_dir_t;
   // ======================================================================
   // Cycle times and their clock counts at 25 ns (maxima, rounded down).
   localparam int CLK_PS   = 25000;
   localparam int T0_NS    = 300000;
   localparam int T1_NS    = 500000;
   localparam int T2_NS    = 1000000;
   localparam int T3_NS    = 5000000;
   localparam int T4_NS    = 10000000;
   localparam int CYC0_CNT = T0_NS / (CLK_PS / 1000);
   localparam int CYC1_CNT = T1_NS / (CLK_PS / 1000);
   localparam int CYC2_CNT = T2_NS / (CLK_PS / 1000);
   localparam int CYC3_CNT = T3_NS / (CLK_PS / 1000);
   localparam int CYC4_CNT = T4_NS / (CLK_PS / 1000);
endpackage

// >>> hw/dec_top.sv
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module dec_top #(
   parameter int CYC0 = dec_pkg::CYC0_CNT,
   parameter int CYC1 = dec_pkg::CYC1_CNT,
   parameter int CYC2 = dec_pkg::CYC2_CNT,
   parameter int CYC3 = dec_pkg::CYC3_CNT,
   parameter int CYC4 = dec_pkg::CYC4_CNT
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             meas_trig,
   input  wire logic        meas_ready,
   input  wire logic [15:0] meas_dist,
   input  wire logic [11:0] meas_level,
   input  wire logic [2:0]  stable_sel,
   output logic             q_out,
   output logic             irq
);
   import dec_pkg::*;

   // ======================================================================
   // Bus slave
   // The slave never stalls, so every transfer completes in one data phase.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   logic       wr_pend_ff;   // A write data phase is running.
   logic [7:0] wr_addr_ff;   // Word address of that write.
   wire        a_go = hsel & hready & htrans[1];
   wire        a_wr = a_go & hwrite;
   wire        a_rd = a_go & ~hwrite;

   // Capture the address phase of a write for use in its data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= a_wr;
         wr_addr_ff <= {haddr[7:2], 2'b00};
      end
   end

   // Write strobes, one per writable register.
   wire w_ctrl = wr_pend_ff & (wr_addr_ff == A_CTRL);
   wire w_near = wr_pend_ff & (wr_addr_ff == A_NEAR);
   wire w_far  = wr_pend_ff & (wr_addr_ff == A_FAR);
   wire w_hmin = wr_pend_ff & (wr_addr_ff == A_HMIN);
   wire w_hmax = wr_pend_ff & (wr_addr_ff == A_HMAX);
   wire w_hyst = wr_pend_ff & (wr_addr_ff == A_HYST);
   wire w_cofs = wr_pend_ff & (wr_addr_ff == A_COFS);
   wire w_offs = wr_pend_ff & (wr_addr_ff == A_OFFS);
   wire w_stat = wr_pend_ff & (wr_addr_ff == A_STAT);
   wire w_mask = wr_pend_ff & (wr_addr_ff == A_MASK);

   // ======================================================================
   // Configuration registers
   logic [9:0]  ctrl_ff;   // Run, cycle mode, level, analog, direction, mode.
   logic [15:0] near_ff;   // Near window limit, already rounded.
   logic [15:0] far_ff;    // Far window limit, already rounded.
   logic [17:0] hmin_ff;   // Minimum height change, signed.
   logic [17:0] hmax_ff;   // Maximum height change, signed.
   logic [10:0] hyst_ff;   // Hysteresis.
   logic [8:0]  cofs_ff;   // Cycle offset, 1 to 256.
   logic [17:0] offs_ff;   // Measured value offset, signed.
   logic [3:0]  mask_ff;   // Interrupt mask.

   wire        adv      = ctrl_ff[C_ADV];
   wire        run      = ctrl_ff[C_RUN];
   wire        auto_cyc = ctrl_ff[C_AUTO];
   wire        ana_en   = ctrl_ff[C_ANA];
   wire        edge_en  = ctrl_ff[C_EDGE];
   wire [1:0]  dir      = ctrl_ff[C_DIR+1:C_DIR];

   // round to step
   // Limits snap to the nearest step; the top step saturates, not wraps.
   wire [16:0] rnd_sum  = {1'b0, hwdata[15:0]} + {15'h0000, 2'b10};
   wire [15:0] rnd_lim  = rnd_sum[16] ? ~DISC_MASK : (rnd_sum[15:0] & ~DISC_MASK);
   // Hysteresis and cycle offset are held inside their legal range.
   wire [10:0] hyst_in  = (hwdata[31:11] != 21'h0 || hwdata[10:0] > HYST_MAX)
                          ? HYST_MAX : hwdata[10:0];
   wire [8:0]  cofs_in  = (hwdata[31:9] != 23'h0 || hwdata[8:0] > COFS_MAX) ? COFS_MAX
                          : (hwdata[8:0] == 9'h000) ? 9'h001 : hwdata[8:0];
   // Direction may only change at the advanced level, the rest of CTRL always.
   wire [1:0]  dir_in   = adv ? hwdata[C_DIR+1:C_DIR] : dir;
   wire [9:0]  ctrl_in  = {hwdata[C_EDGE], dir_in, hwdata[C_ANA:C_RUN]};

   // Configuration writes. Reset values start a measuring run at once.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= RST_CTRL;
         near_ff <= PHYS_NEAR;
         far_ff  <= PHYS_FAR;
         hmin_ff <= RST_HMIN;
         hmax_ff <= RST_HMAX;
         hyst_ff <= RST_HYST;
         cofs_ff <= RST_COFS;
         offs_ff <= RST_OFFS;
         mask_ff <= 4'h0;
      end else begin
         if (w_ctrl) begin
            ctrl_ff <= ctrl_in;
         end
         if (adv) begin
            if (w_near) near_ff <= rnd_lim;
            if (w_far)  far_ff  <= rnd_lim;
            if (w_hmin) hmin_ff <= hwdata[17:0];
            if (w_hmax) hmax_ff <= hwdata[17:0];
            if (w_hyst) hyst_ff <= hyst_in;
            if (w_cofs) cofs_ff <= cofs_in;
         end
         if (w_offs) begin
            offs_ff <= hwdata[17:0];
         end
         if (w_mask) begin
            mask_ff <= hwdata[3:0];
         end
      end
   end

   // ======================================================================
   // Cycle timer
   logic [18:0] cyc_cnt_ff;  // Clocks elapsed in the running cycle.
   logic [2:0]  sel_ff;      // Cycle time step in use.

   wire [2:0]  sel_use = auto_cyc ? stable_sel : ctrl_ff[C_SEL+2:C_SEL];
   wire [18:0] period  = (sel_ff == 3'd0) ? 19'(CYC0) :
                         (sel_ff == 3'd1) ? 19'(CYC1) :
                         (sel_ff == 3'd2) ? 19'(CYC2) :
                         (sel_ff == 3'd3) ? 19'(CYC3) : 19'(CYC4);
   wire        cyc_end = (cyc_cnt_ff >= period - 19'd1);

   // one trigger per cycle
   // The step is taken only at a cycle boundary, so no cycle is ever cut short.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_cnt_ff <= 19'h0_0000;
         sel_ff     <= 3'd0;
         meas_trig  <= 1'b0;
      end else begin
         meas_trig <= run & cyc_end;
         if (!run || cyc_end) begin
            cyc_cnt_ff <= 19'h0_0000;
            sel_ff     <= sel_use;
         end else begin
            cyc_cnt_ff <= cyc_cnt_ff + 19'd1;
         end
      end
   end

   // ======================================================================
   // Validity and derived values
   // low level invalid
   wire lvl_ok = (meas_level >= LEVEL_MIN);
   wire win_ok = (meas_dist >= near_ff) && (meas_dist <= far_ff);
   wire cur_ok = lvl_ok & win_ok;
   wire [15:0] cur_d = cur_ok ? meas_dist : 16'h0000;

   // ======================================================================
   // History of past output values
   // Entries are not cleared at reset; a fill count says which are real.
   logic [16:0] hist_mem [256];  // {valid, distance} per past cycle.
   logic [7:0]  wp_ff;           // Next entry to write.
   logic [8:0]  fill_ff;         // Entries written, saturating at 256.

   wire [7:0]  rp      = wp_ff - cofs_ff[7:0];
   wire [16:0] old_e   = hist_mem[rp];
   wire        old_ok  = old_e[16] & (fill_ff >= cofs_ff);

   // Store each blanked or valid result for later comparison.
   always_ff @(posedge hclk) begin
      if (meas_ready) begin
         hist_mem[wp_ff] <= {cur_ok, cur_d};
      end
   end

   // Write pointer and fill count.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_ff   <= 8'h00;
         fill_ff <= 9'h000;
      end else if (meas_ready) begin
         wp_ff <= wp_ff + 8'd1;
         if (fill_ff != COFS_MAX) fill_ff <= fill_ff + 9'd1;
      end
   end

   // ======================================================================
   // Edge height change evaluation
   wire signed [17:0] diff  = $signed({2'b00, meas_dist}) - $signed({2'b00, old_e[15:0]});
   wire signed [17:0] mag   = diff[17] ? -diff : diff;
   wire signed [18:0] on_lo = 19'($signed(hmin_ff));
   wire signed [18:0] on_hi = 19'(hmax_ff);
   wire signed [18:0] of_lo = 19'($signed(hmin_ff)) - $signed({8'h00, hyst_ff});
   wire signed [18:0] of_hi = 19'($signed(hmax_ff)) + $signed({8'h00, hyst_ff});
   wire signed [18:0] mag_x = 19'(mag);
   wire               pair  = cur_ok & old_ok;

   wire dir_ok = (dir == DIR_POS) ? (diff > 18'sd0) :
                 (dir == DIR_NEG) ? (diff < 18'sd0) : 1'b1;
   wire in_band = (mag_x >= $signed(on_lo)) && (mag_x <= $signed(on_hi));
   wire in_hold = (mag_x >= of_lo) && (mag_x <= of_hi);
   wire q_on    = pair & dir_ok & in_band;
   wire q_keep  = pair & dir_ok & in_hold;

   logic [15:0] dist_ff;   // Last absolute distance, zero when blanked.
   logic        valid_ff;  // Last measurement was valid.
   logic [11:0] level_ff;  // Last received signal level.
   logic        lin_ff;    // Last distance lay in the linear range.

   // edge mode switching output
   // The output only moves when a new result arrives or edge mode is switched off, so it holds per cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q_out    <= 1'b0;
         dist_ff  <= 16'h0000;
         valid_ff <= 1'b0;
         level_ff <= 12'h000;
         lin_ff   <= 1'b0;
      end else begin
         if (!edge_en) begin
            q_out <= 1'b0;
         end else if (meas_ready) begin
            q_out <= q_out ? q_keep : q_on;
         end
         if (meas_ready) begin
            dist_ff  <= cur_d;
            valid_ff <= cur_ok;
            level_ff <= meas_level;
            lin_ff   <= (meas_dist >= LIN_MIN) && (meas_dist <= LIN_MAX);
         end
      end
   end

   wire [17:0] rel_v = valid_ff ? ({2'b00, dist_ff} + offs_ff) : 18'h0_0000;
   wire [15:0] ana_v = (ana_en && valid_ff) ? (dist_ff - near_ff) : 16'h0000;

   // ======================================================================
   // Interrupt status
   logic [3:0] stat_ff;    // Sticky events, write one to clear.
   logic       q_prev_ff;  // Output value one clock ago.

   wire [3:0] ev = {meas_ready & ~cur_ok, ~q_out & q_prev_ff,
                    q_out & ~q_prev_ff, meas_ready};
   wire [3:0] clr = w_stat ? hwdata[3:0] : 4'h0;

   // A new event in the clearing cycle wins over the clear.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_ff   <= 4'h0;
         q_prev_ff <= 1'b0;
         irq       <= 1'b0;
      end else begin
         stat_ff   <= (stat_ff & ~clr) | ev;
         q_prev_ff <= q_out;
         irq       <= |(((stat_ff & ~clr) | ev) & mask_ff);
      end
   end

   // ======================================================================
   // Read data
   wire [7:0]  ra = {haddr[7:2], 2'b00};
   wire [31:0] rd_mux =
      (ra == A_CTRL) ? {22'h00_0000, ctrl_ff} :
      (ra == A_NEAR) ? {16'h0000, near_ff} :
      (ra == A_FAR)  ? {16'h0000, far_ff} :
      (ra == A_HMIN) ? {{14{hmin_ff[17]}}, hmin_ff} :
      (ra == A_HMAX) ? {{14{hmax_ff[17]}}, hmax_ff} :
      (ra == A_HYST) ? {21'h00_0000, hyst_ff} :
      (ra == A_COFS) ? {23'h00_0000, cofs_ff} :
      (ra == A_OFFS) ? {{14{offs_ff[17]}}, offs_ff} :
      (ra == A_STAT) ? {28'h000_0000, stat_ff} :
      (ra == A_MASK) ? {28'h000_0000, mask_ff} :
      (ra == A_DIST) ? {15'h0000, valid_ff, dist_ff} :
      (ra == A_REL)  ? {{14{rel_v[17]}}, rel_v} :
      (ra == A_ANA)  ? {16'h0000, ana_v} :
      (ra == A_INFO) ? {11'h000, sel_ff, lin_ff, q_out, 4'h0, level_ff} : 32'h0000_0000;

   // Read data is latched at the address phase and stands in the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (a_rd) begin
         hrdata <= rd_mux;
      end
   end
endmodule

// >>> tb/dec_chk_asserts.sv
`timescale 1ns/1ps
// ======================================================================
// Port checks of the edge change detector.
module dec_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        meas_trig,
   input wire logic        meas_ready,
   input wire logic        q_out,
   input wire logic        irq
);
   logic dph_wr_ff;  // A write data phase is in progress.
   // Track write data phases, the only bus path that may move q_out or irq.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_ff <= 1'b0;
      end else begin
         dph_wr_ff <= hsel && hready && htrans[1] && hwrite;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ======================================================================
   // Assertions.
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   chk_trig_gap: assert property (meas_trig |=> !meas_trig [*8])
      else $error("measurement starts too close together");
   chk_meas_start: assert property ($rose(hresetn) |-> ##[1:200] meas_trig)
      else $error("no measurement after reset");
   chk_q_rise: assert property ($rose(q_out) |-> $past(meas_ready))
      else $error("output rose without a measurement");
   chk_q_fall: assert property ($fell(q_out) |-> $past(meas_ready)
      || $past(dph_wr_ff, 2) || $past(dph_wr_ff, 3))
      else $error("output fell without a cause");
   chk_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite)
      |=> $stable(hrdata))
      else $error("read data moved without a read");
   // Done and invalid events reach irq one edge after meas_ready, output edges two.
   chk_irq_rise: assert property ($rose(irq) |-> $past(meas_ready) || $past(meas_ready, 2)
      || $past(dph_wr_ff, 2))
      else $error("interrupt rose without a cause");
   // A status clear drops irq at the data phase edge, a mask write one edge later.
   chk_irq_fall: assert property ($fell(irq) |-> $past(dph_wr_ff) || $past(dph_wr_ff, 2))
      else $error("interrupt fell without a write");
   cov_q_on: cover property ($rose(q_out));
   cov_irq_on: cover property ($rose(irq));
   cov_trig: cover property (meas_trig ##1 !meas_trig);
endmodule
bind dec_top dec_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .meas_trig(meas_trig), .meas_ready(meas_ready), .q_out(q_out),
   .irq(irq));

// >>> tb/dec_fe_model.sv
`timescale 1ns/1ps
// ======================================================================
// Optical front end: answers each start pulse DLY+1 clocks after sampling it.
module dec_fe_model #(
   parameter int DLY = 2
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        meas_trig,
   input  wire logic [15:0] dist_in,
   input  wire logic [11:0] level_in,
   output logic             meas_ready,
   output logic [15:0]      meas_dist,
   output logic [11:0]      meas_level
);
   int cnt_ff;  // Clocks left until the answer; -1 while idle.
   // Data is inverted after the pulse so a stale value is never usable.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= -1;
         meas_ready <= 1'b0;
         meas_dist <= 16'h0000;
         meas_level <= 12'h000;
      end else begin
         meas_ready <= 1'b0;
         if (meas_trig) begin
            cnt_ff <= DLY;
         end else if (cnt_ff > 0) begin
            cnt_ff <= cnt_ff - 1;
         end else if (cnt_ff == 0) begin
            cnt_ff <= -1;
            meas_ready <= 1'b1;
            meas_dist <= dist_in;
            meas_level <= level_in;
         end else if (meas_ready) begin
            meas_dist <= ~meas_dist;
            meas_level <= ~meas_level;
         end
      end
   end
endmodule

// >>> tb/test_distance_edge_change_detector.sv
`timescale 1ns/1ps
module test_distance_edge_change_detector;
   import dec_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        meas_trig, meas_ready, q_out, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, stable_sel;
   logic [15:0] meas_dist, fe_dist;
   logic [11:0] meas_level, fe_level;
   int          err_total, total_checks;
   logic [7:0]  ra[9] = '{A_CTRL, A_NEAR, A_FAR, A_HMIN, A_HMAX, A_HYST, A_COFS, A_MASK, 8'h38};
   logic [31:0] rv[9] = '{32'h0000_0003, 32'h0000_07D0, 32'h0000_2710, 32'h0000_0064,
      32'h0000_03E8, 32'h0000_0005, 32'h0000_0008, 32'h0000_0000, 32'h0000_0000};
   logic [15:0] hd[7] = '{16'h1388, 16'h1388, 16'h13EC, 16'h144C, 16'h14AA, 16'h1900, 16'h1900};
   logic        hq[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   assign hready = hreadyout;  // Single slave drives the bus ready.
   always #12.5 hclk = ~hclk;
   dec_top #(.CYC0(20), .CYC1(30), .CYC2(40), .CYC3(50), .CYC4(60)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_trig(meas_trig),
      .meas_ready(meas_ready), .meas_dist(meas_dist), .meas_level(meas_level),
      .stable_sel(stable_sel), .q_out(q_out), .irq(irq));
   dec_fe_model u_fe (.hclk(hclk), .hresetn(hresetn), .meas_trig(meas_trig),
      .dist_in(fe_dist), .level_in(fe_level), .meas_ready(meas_ready),
      .meas_dist(meas_dist), .meas_level(meas_level));
   // ======================================================================
   // Verdict and comparison.
   task automatic results;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // ======================================================================
   // Bus access; the master never assumes a wait count.
   task automatic hwait;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         results();
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      hwait();
      htrans <= 2'b00;
      hwdata <= wd;
      hwait();
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      // One idle cycle lets a preceding write land before the read samples it.
      @(posedge hclk);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask
   // One measurement with the given distance and level, then the output.
   task automatic meas(input logic [15:0] d, input logic [11:0] lv, input logic eq);
      int n;
      fe_dist <= d;
      fe_level <= lv;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (meas_ready !== 1'b1 && n < 400);
      if (n >= 400) begin
         err_total++;
         results();
      end
      repeat (2) @(posedge hclk);
      chk({31'h0, q_out}, {31'h0, eq});
   endtask
   // ======================================================================
   // Main sequence.
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      stable_sel = 3'b000;
      fe_dist = 16'h1388;
      fe_level = 12'h100;
      err_total = 0;
      total_checks = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (ra[i]) rchk(ra[i], rv[i]);
      chk({31'h0, irq}, 32'h0000_0000);
      // Automatic mode takes the stable step at the next cycle boundary.
      stable_sel <= 3'd2;
      repeat (24) @(posedge hclk);
      bus(1'b0, A_INFO, 32'h0000_0000);
      chk(rd & 32'h001C_0000, 32'h0008_0000);
      bus(1'b1, A_NEAR, 32'h0000_0BB8);
      rchk(A_NEAR, 32'h0000_07D0);
      // Fixed cycle time, as edge mode needs steady spacing.
      bus(1'b1, A_CTRL, 32'h0000_0221);
      bus(1'b1, A_NEAR, 32'h0000_07D3);
      rchk(A_NEAR, 32'h0000_07D4);
      bus(1'b1, A_NEAR, 32'h0000_07D1);
      rchk(A_NEAR, 32'h0000_07D0);
      bus(1'b1, A_COFS, 32'h0000_0001);
      foreach (hd[i]) meas(hd[i], 12'h100, hq[i]);
      for (int k = 1; k < 3; k++) begin
         bus(1'b1, A_CTRL, 32'h0000_0221 | (32'(k) << 7));
         meas(16'h1900, 12'h100, 1'b0);
         meas(16'h1838, 12'h100, k == 2);
         meas(16'h1900, 12'h100, k == 1);
      end
      bus(1'b1, A_CTRL, 32'h0000_0221);
      bus(1'b1, A_COFS, 32'h0000_0004);
      for (int i = 0; i < 9; i++) begin
         // Entry 2 still sees the 1838 result left four cycles back by the direction test.
         meas(i < 4 ? 16'h1900 : 16'h1838, 12'h100, i == 2 || i inside {[4:7]});
      end
      bus(1'b1, A_MASK, 32'h0000_0008);
      // Blanked distance kept well below the near window limit.
      meas(16'h05DC, 12'h100, 1'b0);
      rchk(A_DIST, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0001);
      meas(16'h1388, 12'h03F, 1'b0);
      rchk(A_DIST, 32'h0000_0000);
      meas(16'h1388, 12'h100, 1'b0);
      rchk(A_DIST, 32'h0001_1388);
      bus(1'b0, A_REL, 32'h0000_0000);
      chk(rd & 32'h0003_FFFF, 32'h0003_FC18);
      rchk(A_ANA, 32'h0000_0000);
      bus(1'b1, A_CTRL, 32'h0000_0261);
      meas(16'h1388, 12'h100, 1'b0);
      rchk(A_ANA, 32'h0000_0BB8);
      bus(1'b1, A_STAT, 32'h0000_0008);
      repeat (3) @(posedge hclk);
      chk({31'h0, irq}, 32'h0000_0000);
      results();
   end
   // Hang guard.
   initial begin
      repeat (100000) @(posedge hclk);
      err_total++;
      results();
   end
endmodule
